// File: verilog/fbwpc_top.sv
// Contract
// - after freeze accepted, the protection map changes only when permanent lock programming completes
// - freeze is volatile; only power-up reset clears it
// - freeze is opcode 8DH alone between chip select fall and rise
// - permanent lock command governs whether write-lock bits may change
// - permanent lock is opcode E8H plus exactly 18 data bytes
// - after chip select rises, program lock bits; only status reads meanwhile
// - busy flag reports self-timed programming lasting page program time
// - data bytes arrive most significant bit first and assemble so
// - global unlock clears write locks except permanently locked ones
// - global unlock is opcode 98H alone within one chip select frame
// - map: pairs 143..128, 32K locks 127/126, 64K from 125 down
// - permanent lock bits are one-time programmable, never cleared
// - opcode 06H sets write enable latch; protection changes need it
// - map write 42H carries 18 bytes MSB first replacing the map
`timescale 1ns/100ps
`default_nettype none
module fbwpc_top
  import fbwpc_pkg::*;
#(
  parameter int PROG_CYCLES = fbwpc_pkg::PROG_CYCLES_DEFAULT
) (
  input  wire logic                            clk,
  input  wire logic                            rst_n,
  input  wire logic                            en,
  input  wire logic                            nv_init_n,
  input  wire logic                            sck,
  input  wire logic                            ce_n,
  input  wire logic                            si,
  output logic                                 so,
  output logic                                 so_oe_n,
  output logic     [fbwpc_pkg::MAP_WIDTH-1:0]  block_protection_map,
  output logic     [fbwpc_pkg::MAP_WIDTH-1:0]  nv_write_lock,
  output logic                                 map_frozen,
  output logic                                 write_enable_latch,
  output logic                                 busy
);
  import fbwpc_pkg::*;

  // ==========================================================
  // link domain: shift in opcode and data on sck
  logic                       link_clear;
  logic                       frame_fresh;
  logic [FRAME_CNT_WIDTH-1:0] frame_bits;
  logic [SHIFT_WIDTH-1:0]     frame_shift;
  logic                       frame_id;
  logic                       status_read;
  logic [7:0]                 status_shift;
  logic [1:0]                 status_link;
  logic [7:0]                 next_opcode;

  assign next_opcode = {frame_shift[6:0], si};

  // sck stops outside frames, so frame start is marked by chip select
  // itself; the armed flag is preset while chip select is high
  always_ff @(posedge sck or posedge ce_n) begin
    if (ce_n) begin
      frame_fresh <= 1'b1;
    end else begin
      frame_fresh <= 1'b0;
    end
  end

  // count is held after the frame so the core can judge its length
  always_ff @(posedge sck or posedge link_clear) begin
    if (link_clear) begin
      frame_bits <= '0;
      frame_id   <= 1'b0;
    end else if (frame_fresh) begin
      frame_bits <= 8'h01;
      frame_id   <= ~frame_id;
    end else if (frame_bits != FRAME_CNT_MAX) begin
      frame_bits <= frame_bits + 8'h01;
    end
  end

  // msb first: each new bit enters at the bottom
  always_ff @(posedge sck) begin
    frame_shift <= {frame_shift[SHIFT_WIDTH-2:0], si};
  end

  fbwpc_sync #(
    .WIDTH    (2)
  ) u_status_sync (
    .clk      (sck),
    .async_in ({write_enable_latch, busy}),
    .sync_out (status_link)
  );

  // status byte repeats until chip select rises
  always_ff @(posedge sck or posedge link_clear) begin
    if (link_clear) begin
      status_read  <= 1'b0;
      status_shift <= 8'h00;
    end else if (frame_fresh) begin
      status_read  <= 1'b0;
    end else if (frame_bits == (SHORT_FRAME_BITS - 8'h01) &&
                 next_opcode == OP_READ_STATUS) begin
      status_read  <= 1'b1;
      status_shift <= {6'h00, status_link};
    end else if (status_read) begin
      status_shift <= {status_shift[6:0], status_shift[7]};
    end
  end

  always_ff @(negedge sck or posedge ce_n) begin
    if (ce_n) begin
      so      <= 1'b0;
      so_oe_n <= 1'b1;
    end else begin
      so      <= status_read & status_shift[7];
      so_oe_n <= ~status_read;
    end
  end

  // ==========================================================
  // crossing: chip select level into the core clock
  logic ce_sync;
  logic ce_last;
  logic frame_seen;
  logic frame_end;

  fbwpc_sync #(
    .WIDTH    (1)
  ) u_ce_sync (
    .clk      (clk),
    .async_in (ce_n),
    .sync_out (ce_sync)
  );

  // link registers are still while chip select is high; the host must
  // keep it high for at least four core clocks between frames
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ce_last    <= 1'b1;
      frame_seen <= 1'b0;
      link_clear <= 1'b1;
    end else if (en) begin
      ce_last    <= ce_sync;
      link_clear <= 1'b0;
      if (frame_end) begin
        frame_seen <= frame_id;
      end
    end
  end

  // a frame with no sck edges leaves frame_id unchanged and is dropped
  assign frame_end = ce_sync & ~ce_last & (frame_id != frame_seen);

  // ==========================================================
  // command decode at end of frame
  logic       short_frame;
  logic       long_frame;
  logic [7:0] short_op;
  logic [7:0] long_op;
  logic [MAP_WIDTH-1:0] frame_data;
  logic       cmd_write_enable_cmd;
  logic       cmd_wrdi;
  logic       cmd_freeze;
  logic       cmd_unlock;
  logic       cmd_nv_lock;
  logic       cmd_map_write;
  logic       core_idle;
  fbwpc_state_type state;

  assign short_frame = frame_end & (frame_bits == SHORT_FRAME_BITS);
  assign long_frame  = frame_end & (frame_bits == LONG_FRAME_BITS);
  assign short_op    = frame_shift[OPCODE_BITS-1:0];
  assign long_op     = frame_shift[SHIFT_WIDTH-1:MAP_WIDTH];
  assign frame_data  = frame_shift[MAP_WIDTH-1:0];
  assign core_idle   = (state == ST_IDLE);

  // while programming, only status reads are served
  assign cmd_write_enable_cmd      = core_idle & short_frame &
                         (short_op == OP_WRITE_ENABLE);
  assign cmd_wrdi      = core_idle & short_frame &
                         (short_op == OP_WRITE_DISABLE);
  assign cmd_freeze    = core_idle & short_frame &
                         (short_op == OP_FREEZE);
  assign cmd_unlock    = core_idle & short_frame &
                         (short_op == OP_UNLOCK);
  assign cmd_nv_lock   = core_idle & long_frame &
                         (long_op == OP_NV_LOCK);
  assign cmd_map_write = core_idle & long_frame &
                         (long_op == OP_MAP_WRITE);

  // ==========================================================
  // programming timer and state
  logic                      prog_start;
  logic                      prog_done;
  logic [MAP_WIDTH-1:0]      prog_pending;

  assign prog_start = cmd_nv_lock & write_enable_latch;

  fbwpc_timer #(
    .WIDTH (PROG_CNT_WIDTH)
  ) u_prog_timer (
    .clk   (clk),
    .rst_n (rst_n),
    .en    (en),
    .start (prog_start),
    .load  (PROG_CNT_WIDTH'(PROG_CYCLES)),
    .done  (prog_done)
  );

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      busy  <= 1'b0;
    end else if (en) begin
      case (state)
        ST_IDLE: begin
          if (prog_start) begin
            state <= ST_PROGRAM;
            busy  <= 1'b1;
          end
        end
        ST_PROGRAM: begin
          if (prog_done) begin
            state <= ST_IDLE;
            busy  <= 1'b0;
          end
        end
        default: begin
          state <= ST_IDLE;
          busy  <= 1'b0;
        end
      endcase
    end
  end

  // only write-lock positions can be made permanent
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prog_pending <= '0;
    end else if (en && prog_start) begin
      prog_pending <= frame_data & WRITE_LOCK_MASK;
    end
  end

  // ==========================================================
  // write enable latch
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      write_enable_latch <= 1'b0;
    end else if (en) begin
      if (cmd_write_enable_cmd) begin
        write_enable_latch <= 1'b1;
      end else if (cmd_wrdi) begin
        write_enable_latch <= 1'b0;
      end else if (prog_done) begin
        write_enable_latch <= 1'b0;
      end else if ((cmd_freeze | cmd_unlock | cmd_map_write) &&
                   write_enable_latch) begin
        write_enable_latch <= 1'b0;
      end
    end
  end

  // ==========================================================
  // freeze flag, cleared only by power-up reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      map_frozen <= 1'b0;
    end else if (en && cmd_freeze && write_enable_latch) begin
      map_frozen <= 1'b1;
    end
  end

  // ==========================================================
  // nonvolatile lock bits: set only, never cleared by commands
  always_ff @(posedge clk) begin
    if (!nv_init_n) begin
      nv_write_lock <= NV_RESET;
    end else if (en && prog_done) begin
      nv_write_lock <= nv_write_lock | prog_pending;
    end
  end

  // ==========================================================
  // protection map
  logic [MAP_WIDTH-1:0] map_kept_locks;

  // permanently locked blocks keep their write lock whatever is sent
  assign map_kept_locks = nv_write_lock & WRITE_LOCK_MASK;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      block_protection_map <= MAP_RESET | map_kept_locks;
    end else if (en) begin
      if (prog_done) begin
        block_protection_map <= block_protection_map | prog_pending;
      end else if (write_enable_latch && !map_frozen) begin
        if (cmd_unlock) begin
          block_protection_map <= (block_protection_map &
                                   ~WRITE_LOCK_MASK) |
                                  map_kept_locks;
        end else if (cmd_map_write) begin
          block_protection_map <= frame_data |
                                  map_kept_locks;
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: verilog/fbwpc_pkg.sv
`default_nettype none
package fbwpc_pkg;
  // ==========================================================
  // command opcodes
  localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_READ_STATUS   = 8'h05;
  localparam logic [7:0] OP_FREEZE        = 8'h8D;
  localparam logic [7:0] OP_NV_LOCK       = 8'hE8;
  localparam logic [7:0] OP_UNLOCK        = 8'h98;
  localparam logic [7:0] OP_MAP_WRITE     = 8'h42;

  // ==========================================================
  // frame geometry
  localparam int OPCODE_BITS     = 8;
  localparam int DATA_BYTES      = 18;
  localparam int MAP_WIDTH       = 144;
  localparam int SHIFT_WIDTH     = 152;
  localparam int FRAME_CNT_WIDTH = 8;
  localparam logic [7:0] SHORT_FRAME_BITS = 8'h08;
  localparam logic [7:0] LONG_FRAME_BITS  = 8'h98;
  localparam logic [7:0] FRAME_CNT_MAX    = 8'hFF;

  // ==========================================================
  // map field positions
  localparam int PARAM_BLOCK_MSB = 143;
  localparam int PARAM_BLOCK_LSB = 128;
  localparam int TOP32_POS       = 127;
  localparam int BOTTOM32_POS    = 126;
  localparam int BLOCK64_MSB     = 125;

  // write-lock positions: even bits of the pairs, all 32K/64K bits
  localparam logic [143:0] WRITE_LOCK_MASK =
    {16'h5555, 128'hFFFFFFFFFFFFFFFFFFFFFFFFFFFFFFFF};
  // power-up: every block write locked, no block read locked
  localparam logic [143:0] MAP_RESET = WRITE_LOCK_MASK;
  localparam logic [143:0] NV_RESET  = 144'h0;

  // ==========================================================
  // status byte bit positions
  localparam int STAT_BUSY_POS = 0;
  localparam int STAT_WEL_POS  = 1;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS           = 50;
  localparam int PAGE_PROGRAM_TIME_NS    = 1500000;
  localparam int PROG_CYCLES_DEFAULT     =
    PAGE_PROGRAM_TIME_NS / CLK_PERIOD_NS;
  localparam int PROG_CNT_WIDTH          = 24;

  // ==========================================================
  // core state machine
  typedef enum logic [1:0] {
    ST_IDLE    = 2'b01,
    ST_PROGRAM = 2'b10
  } fbwpc_state_type;
endpackage
`default_nettype wire

// File: verilog/fbwpc_sync.sv
`timescale 1ns/100ps
`default_nettype none
module fbwpc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;

  // first stage feeds only the second stage
  always_ff @(posedge clk) begin
    stage1   <= async_in;
    sync_out <= stage1;
  end
endmodule
`default_nettype wire

// File: verilog/fbwpc_timer.sv
`timescale 1ns/100ps
`default_nettype none
module fbwpc_timer #(
  parameter int WIDTH = 24
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             en,
  input  wire logic             start,
  input  wire logic [WIDTH-1:0] load,
  output logic                  done
);
  logic [WIDTH-1:0] remain;
  logic             running;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      remain  <= '0;
      running <= 1'b0;
      done    <= 1'b0;
    end else if (en) begin
      done <= 1'b0;
      if (start) begin
        remain  <= load;
        running <= 1'b1;
      end else if (running) begin
        if (remain <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
          running <= 1'b0;
          done    <= 1'b1;
        end else begin
          remain <= remain - {{(WIDTH-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: verif/fbwpc_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module fbwpc_asserts
  import fbwpc_pkg::*;
#(
  parameter int PROG_CYCLES = 20
) (
  input wire logic         clk,
  input wire logic         rst_n,
  input wire logic         en,
  input wire logic         nv_init_n,
  input wire logic         ce_n,
  input wire logic         so_oe_n,
  input wire logic [143:0] block_protection_map,
  input wire logic [143:0] nv_write_lock,
  input wire logic         map_frozen,
  input wire logic         write_enable_latch,
  input wire logic         busy
);
  localparam int BLO = PROG_CYCLES + 1;
  localparam int BHI = PROG_CYCLES + 2;
  default clocking cb @(posedge clk); endclocking
  // timing is counted in clk cycles; a frozen core disables the checks
  default disable iff (!rst_n || !en);
  // ==========
  // checks
  sequence prog_run;
    ##[BLO:BHI] $fell(busy);
  endsequence
  sequence prog_end;
    $fell(busy) ##0 !write_enable_latch;
  endsequence
  busy_len_a: assert property ($rose(busy) |-> prog_run)
    else $error("programming time wrong");
  wel_clear_a: assert property ($fell(busy) |-> prog_end)
    else $error("latch kept after programming");
  freeze_wel_a: assert property ($rose(map_frozen) |->
    $past(write_enable_latch) && !write_enable_latch)
    else $error("freeze without latch");
  frozen_hold_a: assert property (map_frozen |=> map_frozen)
    else $error("freeze dropped");
  frozen_map_a: assert property (map_frozen |=>
    ($stable(block_protection_map) || $fell(busy)))
    else $error("map changed while frozen");
  nv_keep_a: assert property (nv_init_n && $past(nv_init_n) |->
    ((nv_write_lock & $past(nv_write_lock)) == $past(nv_write_lock)))
    else $error("lock bit cleared");
  nv_mask_a: assert property (
    (nv_write_lock & ~WRITE_LOCK_MASK) == 144'h0)
    else $error("lock bit off the write positions");
  nv_map_a: assert property (!busy |->
    ((block_protection_map & nv_write_lock) == nv_write_lock))
    else $error("locked block shown writable");
  map_wel_a: assert property (
    !$stable(block_protection_map) && !$fell(busy) |->
    $past(write_enable_latch))
    else $error("map changed without latch");
  so_oe_a: assert property (!so_oe_n |-> !ce_n)
    else $error("output driven outside frame");
endmodule
`default_nettype wire

// File: verif/fbwpc_host.sv
`timescale 1ns/100ps
`default_nettype none
module fbwpc_host
  import fbwpc_pkg::*;
(
  output logic      sck,
  output logic      ce_n,
  output logic      si,
  input  wire logic so,
  input  wire logic so_oe_n
);
  // ==========
  // link driver, mode 0; sck still between frames
  initial begin
    sck = 0;
    ce_n = 1;
    si = 0;
  end
  task automatic shift(input logic [151:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      si = v[151-i];
      #6 sck = 1;
      #6 sck = 0;
    end
  endtask
  // gap of 8 clk covers the 4 clk decode and the 200 ns spacing
  task automatic frame(input logic [151:0] v, input int n);
    ce_n = 0;
    #6;
    shift(v, n);
    #6 ce_n = 1;
    si = ~si;
    #400;
  endtask
  task automatic cmd(input logic [7:0] op);
    frame({op, 144'h0}, 8);
  endtask
  task automatic long_cmd(input logic [7:0] op, input logic [143:0] d);
    frame({op, d}, 152);
  endtask
  task automatic read_status(output logic [7:0] st);
    ce_n = 0;
    #6;
    shift({OP_READ_STATUS, 144'h0}, 8);
    for (int i = 0; i < 8; i++) begin
      #6 sck = 1;
      st = {st[6:0], so};
      #6 sck = 0;
    end
    #6 ce_n = 1;
    si = ~si;
    #400;
  endtask
endmodule
`default_nettype wire

// File: verif/fbwpc_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
module fbwpc_top_tb;
  import fbwpc_pkg::*;
  localparam int PROG = 40;
  logic         clk;
  logic         rst_n;
  logic         en;
  logic         nv_init_n;
  logic         sck;
  logic         ce_n;
  logic         si;
  logic         so;
  logic         so_oe_n;
  logic [143:0] map;
  logic [143:0] nv;
  logic         frozen;
  logic         wel;
  logic         busy;
  logic [143:0] d;
  logic [143:0] nvx;
  logic [7:0]   st;
  int           err_total;
  int           samples_checked;
  initial clk = 0;
  always #25 clk = ~clk;
  fbwpc_top #(.PROG_CYCLES(PROG)) uut (
    .clk(clk), .rst_n(rst_n), .en(en), .nv_init_n(nv_init_n),
    .sck(sck), .ce_n(ce_n), .si(si), .so(so), .so_oe_n(so_oe_n),
    .block_protection_map(map), .nv_write_lock(nv),
    .map_frozen(frozen), .write_enable_latch(wel), .busy(busy)
  );
  fbwpc_host host (
    .sck(sck), .ce_n(ce_n), .si(si), .so(so), .so_oe_n(so_oe_n)
  );
  // ==========
  // helpers
  // wide enough for a flag in front of a whole map
  task automatic chk(input logic [159:0] seen, input logic [159:0] want);
    samples_checked++;
    if (seen !== want) begin
      err_total++;
      $display("ERROR %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic stop_test;
    if (err_total == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic prot(input logic [7:0] op, input logic [143:0] v,
                      input bit lng);
    host.cmd(OP_WRITE_ENABLE);
    if (lng) host.long_cmd(op, v);
    else host.cmd(op);
  endtask
  // ==========
  // sequence
  initial begin
    err_total = 0;
    samples_checked = 0;
    en = 1;
    rst_n = 0;
    nv_init_n = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1;
    nv_init_n <= 1;
    repeat (2) @(posedge clk);
    chk(map, WRITE_LOCK_MASK);
    chk({frozen, wel, busy, so_oe_n}, 4'h1);
    host.cmd(OP_UNLOCK);
    chk({wel, map}, {1'h0, WRITE_LOCK_MASK});
    host.cmd(OP_FREEZE);
    chk({frozen, wel}, 2'h0);
    host.cmd(OP_WRITE_ENABLE);
    chk(wel, 1'h1);
    host.read_status(st);
    chk(st, 8'h02);
    host.cmd(OP_UNLOCK);
    chk({wel, map}, 145'h0);
    d = {16'hA5C3, {8{16'h3C96}}};
    prot(OP_MAP_WRITE, d, 1);
    chk(map, d);
    host.cmd(OP_WRITE_ENABLE);
    host.frame({OP_MAP_WRITE, 144'h0}, 151);
    chk(map, d);
    host.cmd(OP_WRITE_DISABLE);
    chk(wel, 1'h0);
    nvx = {16'h0F0F, 120'h0, 8'h81};
    prot(OP_NV_LOCK, nvx, 1);
    chk(busy, 1'h1);
    host.cmd(OP_UNLOCK);
    host.read_status(st);
    chk(st, 8'h03);
    // enable low must hold the programming timer
    @(posedge clk);
    en <= 1'b0;
    repeat (60) @(posedge clk);
    chk(busy, 1'h1);
    en <= 1'b1;
    for (int i = 0; i < 200 && busy !== 1'b0; i++) @(posedge clk);
    if (busy !== 1'b0) begin
      chk(busy, 1'h0);
      stop_test;
    end
    nvx = nvx & WRITE_LOCK_MASK;
    chk(nv, nvx);
    chk({wel, map}, {1'h0, d | nvx});
    prot(OP_UNLOCK, 144'h0, 0);
    chk(map, (d & ~WRITE_LOCK_MASK) | nvx);
    prot(OP_MAP_WRITE, 144'h0, 1);
    chk(map, nvx);
    prot(OP_FREEZE, 144'h0, 0);
    chk({frozen, wel}, 2'h2);
    prot(OP_MAP_WRITE, {144{1'b1}}, 1);
    chk({wel, map}, {1'h0, nvx});
    @(posedge clk);
    rst_n <= 0;
    repeat (6) @(posedge clk);
    rst_n <= 1;
    repeat (2) @(posedge clk);
    chk({frozen, nv}, {1'h0, nvx});
    chk(map, MAP_RESET | nvx);
    prot(OP_MAP_WRITE, 144'h0, 1);
    chk(map, nvx);
    stop_test;
  end
endmodule
bind fbwpc_top fbwpc_asserts #(.PROG_CYCLES(PROG_CYCLES)) chk_i (
  .clk(clk), .rst_n(rst_n), .en(en), .nv_init_n(nv_init_n), .ce_n(ce_n),
  .so_oe_n(so_oe_n), .block_protection_map(block_protection_map),
  .nv_write_lock(nv_write_lock), .map_frozen(map_frozen),
  .write_enable_latch(write_enable_latch), .busy(busy)
);
`default_nettype wire
